// >>> rtl/two_wire_host.sv
// Host sequencer that drives the two-wire bus controller's registers safely
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module two_wire_host
    import two_wire_host_pkg::*;
#(
    parameter int GAP_EDGES = GAP_EDGES_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AV_AW-1:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [AV_DW-1:0] avWritedata,
    output logic [AV_DW-1:0] avReaddata,
    output logic avWaitrequest,
    output dev_acc_s devAcc,
    input wire logic [DEV_DW-1:0] devRdata,
    input wire logic sclPin,
    output logic irq
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    generate
        if (GAP_EDGES < 1 || GAP_EDGES > 7)
        begin : g_bad_gap
            $error("GAP_EDGES must lie in 1..7");
        end
    endgenerate

    typedef enum logic [4:0] {
        S_IDLE = 5'h00,
        S_WAKE = 5'h01,
        S_MCHK_RD = 5'h02,
        S_MCHK_EVAL = 5'h03,
        S_MSET = 5'h04,
        S_MVER_RD = 5'h05,
        S_MVER_EVAL = 5'h06,
        S_MDROP = 5'h07,
        S_ARM_RD = 5'h08,
        S_ARM_EVAL = 5'h09,
        S_ARM_WR = 5'h0a,
        S_REL_WR = 5'h0b,
        S_REL_RD = 5'h0c,
        S_REL_W = 5'h0d,
        S_WB_WR = 5'h0e,
        S_WB_DATA = 5'h0f,
        S_RB_MODE_RD = 5'h10,
        S_RB_MODE_EVAL = 5'h11,
        S_RB_GAP = 5'h12,
        S_RB_WR = 5'h13,
        S_RB_RD = 5'h14,
        S_RB_CAP = 5'h15,
        S_CF_MODE_RD = 5'h16,
        S_CF_MODE_EVAL = 5'h17,
        S_CF_SCL = 5'h18,
        S_CF_WR = 5'h19,
        S_CF_ST_RD = 5'h1a,
        S_CF_ST_EVAL = 5'h1b,
        S_SP_SCL = 5'h1c,
        S_SP_WR = 5'h1d,
        S_ST_WR = 5'h1e,
        S_DONE = 5'h1f
    } state_e;

    state_e state_r;
    state_e stateNxt;
    host_op_e op_r;
    logic [DEV_DW-1:0] data_r;
    logic slvTx_r;
    logic awake_r;
    logic fail_r;
    logic [DEV_DW-1:0] rx_r;
    logic [DEV_DW-1:0] ctlSh_r;
    logic [DEV_DW-1:0] shNxt;
    dev_acc_s accNxt;
    logic [2:0] gapCnt_r;
    logic [EV_W-1:0] evt_r;
    logic [EV_W-1:0] mask_r;
    logic [EV_W-1:0] evtSet;
    logic sclSync;
    logic sclPrev_r;
    logic sclRise;
    logic [2:0] bitCnt;
    logic avAccept;
    logic cmdGo;

    // ----------------------------------------------------------------
    // Link clock sampling
    // ----------------------------------------------------------------
    sync_2ff #(.W(1)) u_scl_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(sclPin),
        .dout(sclSync)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sclPrev_r <= 1'b1;
        else
            sclPrev_r <= sclSync;
    end

    assign sclRise = sclSync & ~sclPrev_r;
    assign bitCnt = devRdata[MODE_BC_MSB:MODE_BC_LSB];

    // ----------------------------------------------------------------
    // Avalon slave: one wait cycle, then the access completes
    // ----------------------------------------------------------------
    assign avAccept = (avRead | avWrite) & ~avWaitrequest;
    assign cmdGo = avAccept & avWrite & (avAddress == REG_CMD) & (state_r == S_IDLE);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avWaitrequest <= 1'b1;
            avReaddata <= '0;
        end
        else if (avWaitrequest && (avRead || avWrite))
        begin
            avWaitrequest <= 1'b0;
            avReaddata <= '0;
            case (avAddress)
                REG_CMD: avReaddata[CMD_OP_MSB:CMD_OP_LSB] <= op_r;
                REG_STATUS:
                begin
                    avReaddata[ST_BUSY] <= (state_r != S_IDLE);
                    avReaddata[ST_AWAKE] <= awake_r;
                    avReaddata[ST_FAIL] <= fail_r;
                    avReaddata[ST_RX_MSB:ST_RX_LSB] <= rx_r;
                end
                REG_EVENT: avReaddata[EV_W-1:0] <= evt_r;
                REG_MASK: avReaddata[EV_W-1:0] <= mask_r;
                default: avReaddata <= '0;
            endcase
        end
        else
        begin
            avWaitrequest <= 1'b1;
        end
    end

    // A command written while busy is dropped; the busy bit tells software why
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_r <= OP_NONE;
            data_r <= '0;
            slvTx_r <= 1'b0;
        end
        else if (cmdGo)
        begin
            op_r <= host_op_e'(avWritedata[CMD_OP_MSB:CMD_OP_LSB]);
            data_r <= avWritedata[CMD_DATA_MSB:CMD_DATA_LSB];
            slvTx_r <= avWritedata[CMD_SLVTX];
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        stateNxt = state_r;
        case (state_r)
            S_IDLE:
            begin
                if (cmdGo)
                begin
                    case (avWritedata[CMD_OP_MSB:CMD_OP_LSB])
                        OP_WAKE: stateNxt = S_WAKE;
                        OP_MASTER: stateNxt = S_MCHK_RD;
                        OP_ARM: stateNxt = S_ARM_RD;
                        OP_RELEASE: stateNxt = S_REL_WR;
                        OP_WRITE: stateNxt = S_WB_WR;
                        OP_READ: stateNxt = avWritedata[CMD_SLVTX] ? S_RB_MODE_RD : S_RB_WR;
                        OP_CLEAR: stateNxt = S_CF_MODE_RD;
                        OP_STOP: stateNxt = S_SP_SCL;
                        OP_START: stateNxt = S_ST_WR;
                        default: stateNxt = S_MDROP;
                    endcase
                    // Until module stop is cancelled only the wake command may touch the device
                    if (!awake_r && avWritedata[CMD_OP_MSB:CMD_OP_LSB] != OP_WAKE)
                        stateNxt = S_MDROP;
                end
            end
            S_MCHK_RD: stateNxt = S_MCHK_EVAL;
            S_MCHK_EVAL: stateNxt = devRdata[CTL_BUS_BUSY_FLAG] ? S_MDROP : S_MSET;
            S_MSET: stateNxt = S_MVER_RD;
            S_MVER_RD: stateNxt = S_MVER_EVAL;
            S_MVER_EVAL: stateNxt = devRdata[CTL_BUS_BUSY_FLAG] ? S_MDROP : S_DONE;
            S_ARM_RD: stateNxt = S_ARM_EVAL;
            S_ARM_EVAL: stateNxt = S_ARM_WR;
            S_REL_WR: stateNxt = S_REL_RD;
            S_REL_RD: stateNxt = S_REL_W;
            S_WB_WR: stateNxt = S_WB_DATA;
            S_RB_MODE_RD: stateNxt = S_RB_MODE_EVAL;
            S_RB_MODE_EVAL: stateNxt = (bitCnt == BC_ZERO) ? S_RB_GAP : S_RB_WR;
            // The first rise ends a clock seen only in part, so one more is counted
            S_RB_GAP:
                if (sclRise && gapCnt_r == 3'(GAP_EDGES))
                    stateNxt = S_RB_WR;
            S_RB_WR: stateNxt = S_RB_RD;
            S_RB_RD: stateNxt = S_RB_CAP;
            S_CF_MODE_RD: stateNxt = S_CF_MODE_EVAL;
            // Counter at 1 means the 8th clock is near: poll until it wraps to 0
            S_CF_MODE_EVAL:
                if (bitCnt >= BC_MIN_SAFE || bitCnt == BC_ZERO)
                    stateNxt = S_CF_SCL;
                else
                    stateNxt = S_CF_MODE_RD;
            S_CF_SCL: stateNxt = sclSync ? S_CF_SCL : S_CF_WR;
            S_CF_WR: stateNxt = S_CF_ST_RD;
            S_CF_ST_RD: stateNxt = S_CF_ST_EVAL;
            S_SP_SCL: stateNxt = sclSync ? S_SP_SCL : S_SP_WR;
            S_WAKE, S_ARM_WR, S_REL_W, S_WB_DATA, S_RB_CAP, S_CF_ST_EVAL, S_SP_WR, S_ST_WR:
                stateNxt = S_DONE;
            default: stateNxt = S_IDLE;
        endcase
    end

    // Control shadow: direction, master select and acknowledge enable the host owns
    always_comb
    begin
        shNxt = ctlSh_r;
        case (stateNxt)
            S_MSET: shNxt[CTL_MST] = 1'b1;
            S_MDROP: shNxt[CTL_MST] = 1'b0;
            S_ARM_WR:
            begin
                shNxt[CTL_DIR] = 1'b0;
                if (devRdata[STAT_ACK_BIT_VALUE])
                    shNxt[CTL_ACK_CHECK_ENABLE] = 1'b0;
            end
            S_REL_WR: shNxt[CTL_DIR] = 1'b0;
            S_WB_WR: shNxt[CTL_DIR] = 1'b0;
            S_RB_WR: shNxt[CTL_DIR] = 1'b1;
            S_ST_WR:
            begin
                shNxt[CTL_DIR] = 1'b1;
                shNxt[CTL_MST] = 1'b1;
                shNxt[CTL_ACK_CHECK_ENABLE] = 1'b1;
            end
            default: shNxt = ctlSh_r;
        endcase
        shNxt = shNxt & CTL_SHADOW_MASK;
    end

    // Device access decoded from the next state, so strobes line up with the state
    always_comb
    begin
        accNxt = '0;
        accNxt.wdata = shNxt;
        accNxt.wdata[CTL_TRANSFER_INTERRUPT_FLAG] = (stateNxt != S_CF_WR);
        accNxt.wdata[CTL_SCP] = !(stateNxt == S_SP_WR || stateNxt == S_ST_WR);
        accNxt.wdata[CTL_BUS_BUSY_FLAG] = (stateNxt == S_ST_WR);
        case (stateNxt)
            S_WAKE:
            begin
                accNxt.wr = 1'b1;
                accNxt.addr = ADDR_MSTOP;
                accNxt.wdata = MSTOP_RUN;
            end
            S_MCHK_RD, S_MVER_RD:
            begin
                accNxt.rd = 1'b1;
                accNxt.addr = ADDR_CTL;
            end
            S_ARM_RD, S_CF_ST_RD:
            begin
                accNxt.rd = 1'b1;
                accNxt.addr = ADDR_STAT;
            end
            S_RB_MODE_RD, S_CF_MODE_RD:
            begin
                accNxt.rd = 1'b1;
                accNxt.addr = ADDR_MODE;
            end
            S_REL_RD, S_RB_RD:
            begin
                accNxt.rd = 1'b1;
                accNxt.addr = ADDR_DATA;
            end
            S_WB_DATA:
            begin
                accNxt.wr = 1'b1;
                accNxt.addr = ADDR_DATA;
                accNxt.wdata = data_r;
            end
            S_MSET, S_MDROP, S_ARM_WR, S_REL_WR, S_WB_WR, S_RB_WR, S_CF_WR, S_SP_WR, S_ST_WR:
            begin
                accNxt.wr = awake_r;
                accNxt.addr = ADDR_CTL;
            end
            default: accNxt.wdata = '0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= S_IDLE;
            ctlSh_r <= CTL_RESET;
            devAcc <= '0;
        end
        else
        begin
            state_r <= stateNxt;
            ctlSh_r <= shNxt;
            devAcc <= accNxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            gapCnt_r <= '0;
        else if (state_r != S_RB_GAP)
            gapCnt_r <= '0;
        else if (sclRise)
            gapCnt_r <= gapCnt_r + 3'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awake_r <= 1'b0;
            fail_r <= 1'b0;
            rx_r <= '0;
        end
        else
        begin
            if (state_r == S_WAKE)
                awake_r <= 1'b1;
            if (state_r == S_RB_CAP)
                rx_r <= devRdata;
            if (state_r == S_MDROP)
                fail_r <= 1'b1;
            else if (state_r == S_DONE)
                fail_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    always_comb
    begin
        evtSet = '0;
        evtSet[EV_DONE] = (state_r == S_DONE);
        evtSet[EV_FAIL] = (state_r == S_MDROP);
        evtSet[EV_AL] = (state_r == S_CF_ST_EVAL) && devRdata[STAT_AL];
    end

    // A new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_r <= '0;
            mask_r <= '0;
        end
        else
        begin
            if (avAccept && avWrite && avAddress == REG_EVENT)
                evt_r <= (evt_r & ~avWritedata[EV_W-1:0]) | evtSet;
            else
                evt_r <= evt_r | evtSet;
            if (avAccept && avWrite && avAddress == REG_MASK)
                mask_r <= avWritedata[EV_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(evt_r & mask_r);
    end

endmodule : two_wire_host

// >>> rtl/two_wire_host_pkg.sv
// Constants, types and command codes shared by the two-wire bus host controller
// What this block does
// - Before slave address reception, host clears direction to receive in the immediate window.
// - Slave clock-low wait is released by clearing direction, then a dummy data read.
// - Data register is read after transmit select (after receive select on release), written only after receive select.
// - As master, host checks the arbitration-lost flag after every frame.
// - Master entry: confirm bus free, set master select, confirm bus still free.
// - With master wait, clear the transfer flag while the bit counter reads 2 or more.
// - If late and counter reads 1 or 0, wait for 0 and clock low, then clear.
// - With slow clock rise or stretching slave, clear the flag only after clock reads low.
// - Issue the stop command only after reading the clock line low.
// - In slave transmit, with counter 000, wait two transfer clocks before reads.
// - After a 1 acknowledge on the last byte, host clears acknowledge enable.
// - With the start command, host sets master select and transmit direction in the same write.
package two_wire_host_pkg;

    // ----------------------------------------------------------------
    // Device register map (device port, byte wide)
    // ----------------------------------------------------------------
    localparam int DEV_AW = 3;
    localparam int DEV_DW = 8;
    localparam logic [DEV_AW-1:0] ADDR_CTL = 3'h0;
    localparam logic [DEV_AW-1:0] ADDR_STAT = 3'h1;
    localparam logic [DEV_AW-1:0] ADDR_MODE = 3'h2;
    localparam logic [DEV_AW-1:0] ADDR_DATA = 3'h3;
    localparam logic [DEV_AW-1:0] ADDR_MSTOP = 3'h4;

    // bus_control_reg fields
    localparam int CTL_ACK_CHECK_ENABLE = 0;
    localparam int CTL_SCP = 1;
    localparam int CTL_TRANSFER_INTERRUPT_FLAG = 2;
    localparam int CTL_BUS_BUSY_FLAG = 3;
    localparam int CTL_DIR = 4;
    localparam int CTL_MST = 5;
    localparam int CTL_EN = 7;
    localparam logic [DEV_DW-1:0] CTL_SHADOW_MASK = 8'hb1;
    localparam logic [DEV_DW-1:0] CTL_RESET = 8'h80;

    // bus_status_reg and bus_mode_reg fields
    localparam int STAT_ACK_BIT_VALUE = 0;
    localparam int STAT_AL = 1;
    localparam int MODE_BC_LSB = 0;
    localparam int MODE_BC_MSB = 2;
    localparam logic [2:0] BC_ZERO = 3'h0;
    localparam logic [2:0] BC_MIN_SAFE = 3'h2;
    localparam logic [DEV_DW-1:0] MSTOP_RUN = 8'h00;

    // ----------------------------------------------------------------
    // Host registers on Avalon-MM (word index)
    // ----------------------------------------------------------------
    localparam int AV_AW = 2;
    localparam int AV_DW = 32;
    localparam logic [AV_AW-1:0] REG_CMD = 2'h0;
    localparam logic [AV_AW-1:0] REG_STATUS = 2'h1;
    localparam logic [AV_AW-1:0] REG_EVENT = 2'h2;
    localparam logic [AV_AW-1:0] REG_MASK = 2'h3;

    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_MSB = 3;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_DATA_MSB = 15;
    localparam int CMD_SLVTX = 16;

    localparam int ST_BUSY = 0;
    localparam int ST_AWAKE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_RX_LSB = 8;
    localparam int ST_RX_MSB = 15;

    localparam int EV_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_AL = 2;

    // Transfer clocks to let pass in slave transmit when the counter reads zero
    localparam int GAP_EDGES_DEF = 2;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_WAKE = 4'h1,
        OP_MASTER = 4'h2,
        OP_ARM = 4'h3,
        OP_RELEASE = 4'h4,
        OP_WRITE = 4'h5,
        OP_READ = 4'h6,
        OP_CLEAR = 4'h7,
        OP_STOP = 4'h8,
        OP_START = 4'h9
    } host_op_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [DEV_AW-1:0] addr;
        logic [DEV_DW-1:0] wdata;
    } dev_acc_s;

endpackage : two_wire_host_pkg

// >>> rtl/sync_2ff.sv
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module sync_2ff
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '1;
            dout <= '1;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : sync_2ff

// >>> testbench/two_wire_host_asserts.sv
// Port assertions for the two-wire host controller
`timescale 1ns/1ps
module two_wire_host_asserts
    import two_wire_host_pkg::*;
#(
    parameter int GAP_EDGES = 2
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic avWaitrequest,
    input wire dev_acc_s devAcc,
    input wire logic sclPin
);
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [4:0] lowAge_r;
    logic [4:0] modeAge_r;
    logic dir_r;
    logic mst_r;
    wire ctlWr = devAcc.wr && devAcc.addr == ADDR_CTL;
    wire flagClr = ctlWr && !devAcc.wdata[CTL_TRANSFER_INTERRUPT_FLAG];
    wire mstSet = ctlWr && devAcc.wdata[CTL_MST] && devAcc.wdata[CTL_SCP] && !mst_r;
    // Ages saturate so that a write long after the last cause still fails
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lowAge_r <= 5'h1f;
        else if (!sclPin)
            lowAge_r <= 5'h00;
        else if (lowAge_r != 5'h1f)
            lowAge_r <= lowAge_r + 5'h01;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            modeAge_r <= 5'h1f;
        else if (devAcc.rd && devAcc.addr == ADDR_MODE)
            modeAge_r <= 5'h00;
        else if (modeAge_r != 5'h1f)
            modeAge_r <= modeAge_r + 5'h01;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {mst_r, dir_r} <= 2'h1;
        else if (ctlWr)
            {mst_r, dir_r} <= {devAcc.wdata[CTL_MST], devAcc.wdata[CTL_DIR]};
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_wait_one: assert property ((avRead || avWrite) && avWaitrequest |=> !avWaitrequest)
        else $error("waitrequest not low one cycle after request");
    a_clear_scl_low: assert property (flagClr |-> lowAge_r < 5'h0a)
        else $error("flag cleared while clock line high");
    a_stop_scl_low: assert property (ctlWr && !devAcc.wdata[CTL_BUS_BUSY_FLAG]
        && !devAcc.wdata[CTL_SCP] |-> lowAge_r < 5'h0a)
        else $error("stop issued while clock line high");
    a_clear_after_count: assert property (flagClr |-> modeAge_r < 5'h1f)
        else $error("flag cleared without reading the counter");
    a_lost_checked: assert property (flagClr |=> ##[0:3] devAcc.rd
        && devAcc.addr == ADDR_STAT)
        else $error("status not read after frame");
    a_master_before: assert property (mstSet |-> $past(devAcc.rd, 2)
        && $past(devAcc.addr, 2) == ADDR_CTL)
        else $error("master select set without busy check");
    a_master_after: assert property (mstSet |=> devAcc.rd && devAcc.addr == ADDR_CTL)
        else $error("busy not rechecked after master select");
    a_data_dir: assert property (devAcc.wr && devAcc.addr == ADDR_DATA |-> !dir_r)
        else $error("data written in transmit direction");
endmodule : two_wire_host_asserts

bind two_wire_host two_wire_host_asserts #(.GAP_EDGES(GAP_EDGES)) u_asserts (.clk(clk),
    .rst_n(rst_n), .avRead(avRead), .avWrite(avWrite), .avWaitrequest(avWaitrequest),
    .devAcc(devAcc), .sclPin(sclPin));

// >>> testbench/two_wire_dev_model.sv
// Behavioural model of the two-wire bus controller behind the host
`timescale 1ns/1ps
module two_wire_dev_model
    import two_wire_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dev_acc_s devAcc,
    input wire logic busyIn,
    input wire logic grabIn,
    input wire logic [DEV_DW-1:0] statIn,
    input wire logic [2:0] bcIn,
    input wire logic sclRun,
    output logic [DEV_DW-1:0] devRdata,
    output logic sclPin
);
    logic awake_r;
    logic [DEV_DW-1:0] ctl_r;
    logic [DEV_DW-1:0] data_r;
    logic dirAtWr_r;
    logic dirAtRd_r;
    logic [DEV_DW-1:0] rdVal;
    // Registers read as zero until module stop is cancelled
    always_comb
    begin
        rdVal = 8'h00;
        if (awake_r)
            case (devAcc.addr)
                ADDR_CTL: rdVal = {ctl_r[7:4], busyIn | (grabIn & ctl_r[CTL_MST]), ctl_r[2:0]};
                ADDR_STAT: rdVal = statIn & {7'h7f, ctl_r[CTL_ACK_CHECK_ENABLE]};
                ADDR_MODE: rdVal = {5'h00, bcIn};
                ADDR_DATA: rdVal = data_r;
                default: rdVal = 8'h00;
            endcase
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awake_r <= 1'b0;
            ctl_r <= CTL_RESET;
            data_r <= 8'h00;
            dirAtWr_r <= 1'b1;
            dirAtRd_r <= 1'b1;
        end
        else if (devAcc.wr && devAcc.addr == ADDR_MSTOP)
            awake_r <= devAcc.wdata == MSTOP_RUN;
        else if (devAcc.wr && awake_r && devAcc.addr == ADDR_CTL)
            ctl_r <= devAcc.wdata;
        else if (devAcc.wr && awake_r && devAcc.addr == ADDR_DATA)
        begin
            data_r <= devAcc.wdata;
            dirAtWr_r <= ctl_r[CTL_DIR];
        end
        else if (devAcc.rd && awake_r && devAcc.addr == ADDR_DATA)
            dirAtRd_r <= ctl_r[CTL_DIR];
    end
    // Read data lives one cycle, then flips so a late sample is seen as wrong
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            devRdata <= 8'h00;
        else if (devAcc.rd)
            devRdata <= rdVal;
        else
            devRdata <= ~devRdata;
    end
    // Clock line rests high by its pull-up outside frames
    initial
    begin
        sclPin = 1'b1;
        #3;
        forever
        begin
            #200;
            sclPin = sclRun ? ~sclPin : 1'b1;
        end
    end
endmodule : two_wire_dev_model

// >>> testbench/two_wire_host_bench.sv
// Self-checking bench for the two-wire host controller
`timescale 1ns/1ps
module two_wire_host_bench
    import two_wire_host_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [AV_AW-1:0] avAddress = 2'h0;
    logic avRead = 1'b0;
    logic avWrite = 1'b0;
    logic [AV_DW-1:0] avWritedata = 32'h0;
    logic [AV_DW-1:0] avReaddata;
    logic avWaitrequest;
    dev_acc_s devAcc;
    logic [DEV_DW-1:0] devRdata;
    logic sclPin;
    logic irq;
    logic busyIn = 1'b0;
    logic grabIn = 1'b0;
    logic [DEV_DW-1:0] statIn = 8'h00;
    logic [2:0] bcIn = 3'h2;
    logic sclRun = 1'b0;
    logic [AV_DW-1:0] expQ[$];
    logic [7:0] b;
    int errors = 0;
    int checks_done = 0;
    two_wire_host #(.GAP_EDGES(2)) i_dut (.clk(clk), .rst_n(rst_n), .avAddress(avAddress),
        .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
        .avWaitrequest(avWaitrequest), .devAcc(devAcc), .devRdata(devRdata), .sclPin(sclPin),
        .irq(irq));
    two_wire_dev_model i_model (.clk(clk), .rst_n(rst_n), .devAcc(devAcc), .busyIn(busyIn),
        .grabIn(grabIn), .statIn(statIn), .bcIn(bcIn), .sclRun(sclRun), .devRdata(devRdata),
        .sclPin(sclPin));
    always #25 clk = ~clk;
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [AV_DW-1:0] e, input logic [AV_DW-1:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [AV_AW-1:0] a, input logic [AV_DW-1:0] d);
        @(posedge clk);
        avAddress <= a;
        avWrite <= w;
        avRead <= !w;
        avWritedata <= d;
        do
            @(posedge clk);
        while (avWaitrequest !== 1'b0);
        avWrite <= 1'b0;
        avRead <= 1'b0;
    endtask : acc
    task automatic rd(input logic [AV_AW-1:0] a, input logic [AV_DW-1:0] e);
        expQ.push_back(e);
        acc(1'b0, a, 32'h0);
    endtask : rd
    function automatic logic [AV_DW-1:0] cmdw(input host_op_e o, input logic [7:0] d,
        input logic g);
        return {15'h0, g, d, 4'h0, o};
    endfunction : cmdw
    // Runs one command, awaits irq, checks and clears events
    task automatic op(input logic [AV_DW-1:0] c, input logic [AV_DW-1:0] ev);
        acc(1'b1, REG_CMD, c);
        for (int n = 0; n < 3000 && irq !== 1'b1; n++)
            @(posedge clk);
        chk("irq_raised", 1'b1, irq);
        repeat (4) @(posedge clk);
        rd(REG_EVENT, ev);
        acc(1'b1, REG_EVENT, 32'h7);
    endtask : op
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------------------------------
    // Read monitor, watchdog and sequence
    // ----------------------------------------------------------------
    always @(posedge clk)
        if (avRead && avWaitrequest === 1'b0)
            chk("readdata", expQ.size() > 0 ? expQ.pop_front() : 32'hx, avReaddata);
    initial
    begin
        #2000000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(57342));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_STATUS, 32'h0);
        rd(REG_EVENT, 32'h0);
        acc(1'b1, REG_MASK, 32'h7);
        op(cmdw(OP_WRITE, 8'h5a, 1'b0), 32'h2);
        rd(REG_STATUS, 32'h4);
        op(cmdw(OP_WAKE, 8'h00, 1'b0), 32'h1);
        rd(REG_STATUS, 32'h2);
        $display("test wake done");
        for (int i = 0; i < 3; i++)
        begin
            busyIn <= (i == 0);
            grabIn <= (i == 1);
            op(cmdw(OP_MASTER, 8'h00, 1'b0), (i == 2) ? 32'h1 : 32'h2);
            chk("master", i == 2, i_model.ctl_r[CTL_MST]);
        end
        $display("test master done");
        b = 8'($urandom);
        acc(1'b1, REG_MASK, 32'h0);
        acc(1'b1, REG_CMD, cmdw(OP_WRITE, b, 1'b0));
        repeat (20) @(posedge clk);
        chk("irq_masked", 1'b0, irq);
        chk("data", b, i_model.data_r);
        chk("dir_write", 1'b0, i_model.dirAtWr_r);
        acc(1'b1, REG_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq_unmasked", 1'b1, irq);
        acc(1'b1, REG_EVENT, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq_cleared", 1'b0, irq);
        acc(1'b1, REG_MASK, 32'h7);
        op(cmdw(OP_READ, 8'h00, 1'b0), 32'h1);
        rd(REG_STATUS, {16'h0, b, 8'h02});
        chk("dir_read", 1'b1, i_model.dirAtRd_r);
        bcIn <= 3'h0;
        sclRun <= 1'b1;
        op(cmdw(OP_READ, 8'h00, 1'b1), 32'h1);
        rd(REG_STATUS, {16'h0, b, 8'h02});
        $display("test data done");
        statIn <= 8'h01;
        op(cmdw(OP_START, 8'h00, 1'b0), 32'h1);
        op(cmdw(OP_ARM, 8'h00, 1'b0), 32'h1);
        chk("ack_enable", 1'b0, i_model.ctl_r[CTL_ACK_CHECK_ENABLE]);
        chk("dir_arm", 1'b0, i_model.ctl_r[CTL_DIR]);
        op(cmdw(OP_RELEASE, 8'h00, 1'b0), 32'h1);
        chk("dir_release", 1'b0, i_model.dirAtRd_r);
        $display("test slave done");
        bcIn <= 3'h2;
        statIn <= 8'h02;
        op(cmdw(OP_CLEAR, 8'h00, 1'b0), 32'h5);
        chk("flag", 1'b0, i_model.ctl_r[CTL_TRANSFER_INTERRUPT_FLAG]);
        op(cmdw(OP_STOP, 8'h00, 1'b0), 32'h1);
        chk("stop", 2'b00, {i_model.ctl_r[CTL_BUS_BUSY_FLAG], i_model.ctl_r[CTL_SCP]});
        $display("test wait done");
        report_and_stop();
    end
endmodule : two_wire_host_bench
